// ==== mmu_tlb_pkg.sv ====
// Constants, address map and carrier types of the TLB maintenance block.
package mmu_tlb_pkg;

  // Address space identifiers per side.
  localparam logic [7:0] IMMU_REG_ASI = 8'h50;
  localparam logic [7:0] IMMU_PTR8K_ASI = 8'h51;
  localparam logic [7:0] IMMU_PTR64K_ASI = 8'h52;
  localparam logic [7:0] IMMU_PTRDIR_ASI = 8'h53;
  localparam logic [7:0] IMMU_DATA_IN_ASI = 8'h54;
  localparam logic [7:0] IMMU_DATA_ACC_ASI = 8'h55;
  localparam logic [7:0] IMMU_TAG_READ_ASI = 8'h56;
  localparam logic [7:0] DMMU_REG_ASI = 8'h58;
  localparam logic [7:0] DMMU_PTR8K_ASI = 8'h59;
  localparam logic [7:0] DMMU_PTR64K_ASI = 8'h5A;
  localparam logic [7:0] DMMU_PTRDIR_ASI = 8'h5B;
  localparam logic [7:0] DMMU_DATA_IN_ASI = 8'h5C;
  localparam logic [7:0] DMMU_DATA_ACC_ASI = 8'h5D;
  localparam logic [7:0] DMMU_TAG_READ_ASI = 8'h5E;

  // Register offsets inside the register space.
  localparam logic [17:0] VA_TRANSLATION_BUFFER_BASE = 18'h0_0028;
  localparam logic [17:0] VA_TAG_ACCESS = 18'h0_0030;
  localparam logic [17:0] VA_TSB_EXT_PRIM = 18'h0_0048;
  localparam logic [17:0] VA_TSB_EXT_SEC = 18'h0_0050;
  localparam logic [17:0] VA_TSB_EXT_NUC = 18'h0_0058;
  localparam logic [17:0] VA_TAG_ACCESS_EXT = 18'h0_0060;

  // Field layouts.
  localparam int SECOND_SET_TLB_PAGE_SIZE_LO = 19;
  localparam int FIRST_SET_TLB_PAGE_SIZE_LO = 16;
  localparam int TLB_SEL_LO = 16;
  localparam logic [1:0] SEL_FULL = 2'h0;
  localparam logic [1:0] SEL_SET = 2'h2;
  localparam int TTE_VALID_POS = 63;
  localparam int TTE_GLOBAL_POS = 0;
  localparam int TTE_SIZE_HI_POS = 48;
  localparam int TTE_SIZE_LO_POS = 61;
  localparam logic [63:0] TRANSLATION_BUFFER_BASE_MASK = 64'hFFFF_FFFF_FFFF_E00F;
  localparam logic [63:0] TAG_EXT_MASK = 64'h0000_0000_003F_0000;
  localparam logic [63:0] PAGE_BASE_MASK = 64'h0000_0000_0000_1FFF;

  // Page size codes and shift arithmetic.
  localparam logic [2:0] PGSZ_8K = 3'h0;
  localparam logic [2:0] PGSZ_4M = 3'h3;
  localparam logic [2:0] PGSZ_MAX = 3'h5;
  localparam logic [5:0] PAGE_SHIFT_BASE = 6'h0D;
  localparam logic [5:0] PAGE_SHIFT_STEP = 6'h03;

  // Reset values.
  localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;
  localparam logic [14:0] PLRU_RESET = 15'h0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] asi;
    logic [17:0] va;
    logic [63:0] wdata;
  } access_req_t;

  typedef struct packed {
    logic valid;
    logic access_exc;
    logic [63:13] va;
    logic [12:0] eff_ctx;
    logic [2:0] first_set_tlb_page_size;
    logic [2:0] second_set_tlb_page_size;
  } trap_info_t;

  typedef struct packed {
    logic full;
    logic set;
    logic [3:0] full_idx;
    logic [8:0] set_idx;
  } tlb_addr_t;

endpackage

// ==== plru_tree16.sv ====
// Tree pseudo-LRU victim selector for the 16-entry fully associative TLB.
`timescale 1ns/1ps
module plru_tree16
  import mmu_tlb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic touch,
  input wire logic [3:0] touch_idx,
  output logic [3:0] victim
);

  // Node n has children 2n and 2n+1; a set bit steers the search right.
  logic [15:1] tree;
  logic [15:1] next_tree;

  always_comb begin
    int node;
    node = 1;
    victim = 4'h0;
    for (int l = 0; l < 4; l++) begin
      victim[3 - l] = tree[node];
      node = node * 2 + int'(tree[node]);
    end
  end

  // Touched path bits point away from the touched entry.
  always_comb begin
    int node;
    node = 1;
    next_tree = tree;
    for (int l = 0; l < 4; l++) begin
      next_tree[node] = ~touch_idx[3 - l];
      node = node * 2 + int'(touch_idx[3 - l]);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tree <= PLRU_RESET;
    end else if (touch) begin
      tree <= next_tree;
    end
  end

endmodule

// ==== mmu_tlb_maintenance_regs.sv ====
// Maintenance registers and entry write/read paths of one MMU's two TLBs.
//
// Overview of operation
// - Trap records effective context, not shared one.
// - Trap captures page sizes into extension register.
// - Size matching neither page size goes full.
// - Access exception traps leave extension undefined.
// - Multi-page disabled makes extension register undefined.
// - Pseudo-LRU full TLB, true LRU per set.
// - Select field: 00 full, 10 set-associative.
// - Full TLB uses low four index bits.
// - Instruction set TLB: half/way 13:12, set 8:3.
// - Data set TLB: half/way 13:12, set 9:3.
// - Global entries via data-in always go full.
// - Tag read uses same address decode.
// - Inconsistent tag access leaves TLB unchanged.
// - Invalid direct writes skip the consistency check.
// - Reading an invalid entry returns zero.
// - Buffer base stores base and size, unused.
// - Buffer extension registers raise access exception.
// - Pointer registers raise access exception.
// - Multi-page disabled means 8 KB and 4 MB.
`timescale 1ns/1ps
module mmu_tlb_maintenance_regs
  import mmu_tlb_pkg::*;
#(
  parameter bit is_data_mmu = 1'b1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire access_req_t req,
  input wire trap_info_t trap,
  input wire logic instr_multi_page_enable,
  input wire logic data_multi_page_enable,
  output logic resp_valid,
  output logic [63:0] resp_data,
  output logic access_exception
);

  // Address spaces of this side.
  localparam logic [7:0] REG_ASI = is_data_mmu ? DMMU_REG_ASI : IMMU_REG_ASI;
  localparam logic [7:0] PTR8K_ASI = is_data_mmu ? DMMU_PTR8K_ASI : IMMU_PTR8K_ASI;
  localparam logic [7:0] PTR64K_ASI = is_data_mmu ? DMMU_PTR64K_ASI : IMMU_PTR64K_ASI;
  localparam logic [7:0] PTRDIR_ASI = is_data_mmu ? DMMU_PTRDIR_ASI : IMMU_PTRDIR_ASI;
  localparam logic [7:0] DATA_IN_ASI = is_data_mmu ? DMMU_DATA_IN_ASI : IMMU_DATA_IN_ASI;
  localparam logic [7:0] DATA_ACC_ASI = is_data_mmu ? DMMU_DATA_ACC_ASI : IMMU_DATA_ACC_ASI;
  localparam logic [7:0] TAG_READ_ASI = is_data_mmu ? DMMU_TAG_READ_ASI : IMMU_TAG_READ_ASI;

  // Direct entry address decode, shared by the data access and tag read paths.
  function automatic tlb_addr_t decode_tlb_addr(input logic [17:0] va);
    tlb_addr_t a;
    a.full = (va[TLB_SEL_LO +: 2] == SEL_FULL);
    a.set = (va[TLB_SEL_LO +: 2] == SEL_SET);
    a.full_idx = va[6:3];
    if (is_data_mmu) begin
      a.set_idx = {va[13], va[12], va[9:3]};
    end else begin
      a.set_idx = {va[13], va[12], 1'b0, va[8:3]};
    end
    return a;
  endfunction

  function automatic logic [5:0] page_shift(input logic [2:0] size);
    return PAGE_SHIFT_BASE + 6'(size) * PAGE_SHIFT_STEP;
  endfunction

  // Tag access is consistent when no address bit lies inside the page offset.
  function automatic logic tag_consistent(input logic [63:0] tag, input logic [2:0] size);
    logic [63:0] offset_mask;
    offset_mask = (64'h0000_0000_0000_0001 << page_shift(size)) - 64'h0000_0000_0000_0001;
    return (size <= PGSZ_MAX) && ((tag & offset_mask & ~PAGE_BASE_MASK) == REG_RESET);
  endfunction

  function automatic logic [2:0] tte_size(input logic [63:0] tte);
    return {tte[TTE_SIZE_HI_POS], tte[TTE_SIZE_LO_POS +: 2]};
  endfunction

  // Entry storage: set index is {half, way, set}.
  logic [63:0] full_tag [16];
  logic [63:0] full_data [16];
  logic [63:0] set_tag [512];
  logic [63:0] set_data [512];
  // One bit per set and half, naming the next victim way: the least recently written one, or the one last invalidated.
  logic [255:0] set_lru;

  logic [63:0] tag_access;
  logic [63:0] tag_access_ext;
  logic [63:0] translation_buffer_base;

  // Access decode.
  logic acc_reg;
  logic acc_data_in;
  logic acc_data_acc;
  logic acc_tag_read;
  logic acc_refused;
  tlb_addr_t dir_addr;

  always_comb begin
    acc_reg = req.valid && (req.asi == REG_ASI);
    acc_data_in = req.valid && (req.asi == DATA_IN_ASI);
    acc_data_acc = req.valid && (req.asi == DATA_ACC_ASI);
    acc_tag_read = req.valid && (req.asi == TAG_READ_ASI);
    acc_refused = req.valid && ((req.asi == PTR8K_ASI) || (req.asi == PTR64K_ASI) ||
                  (req.asi == PTRDIR_ASI));
    if (acc_reg && ((req.va == VA_TSB_EXT_PRIM) || (req.va == VA_TSB_EXT_SEC) ||
        (req.va == VA_TSB_EXT_NUC))) begin
      acc_refused = 1'b1;
    end
    dir_addr = decode_tlb_addr(req.va);
  end

  // Page sizes that steer placement into the set-associative halves.
  logic multi_page;
  logic [2:0] eff_size0;
  logic [2:0] eff_size1;

  always_comb begin
    multi_page = is_data_mmu ? data_multi_page_enable : instr_multi_page_enable;
    // The extension register holds no meaning while multi-page is off.
    eff_size0 = multi_page ? tag_access_ext[FIRST_SET_TLB_PAGE_SIZE_LO +: 3] : PGSZ_8K;
    eff_size1 = multi_page ? tag_access_ext[SECOND_SET_TLB_PAGE_SIZE_LO +: 3] : PGSZ_4M;
  end

  // Entry write planning.
  logic [2:0] new_size;
  logic new_valid;
  logic new_global;
  logic [63:0] set_shifted;
  logic [6:0] in_set;
  logic in_half;
  logic in_way;
  logic [3:0] full_victim;
  logic full_wr;
  logic [3:0] full_wr_idx;
  logic set_wr;
  logic [8:0] set_wr_idx;
  logic lru_wr;
  logic [7:0] lru_idx;
  logic lru_val;

  always_comb begin
    new_size = tte_size(req.wdata);
    new_valid = req.wdata[TTE_VALID_POS];
    new_global = req.wdata[TTE_GLOBAL_POS];
    in_half = (new_size != eff_size0);
    set_shifted = tag_access >> page_shift(new_size);
    in_set = is_data_mmu ? set_shifted[6:0] : {1'b0, set_shifted[5:0]};
    in_way = set_lru[{in_half, in_set}];
    full_wr = 1'b0;
    full_wr_idx = dir_addr.full_idx;
    set_wr = 1'b0;
    set_wr_idx = dir_addr.set_idx;
    lru_wr = 1'b0;
    lru_idx = {dir_addr.set_idx[8], dir_addr.set_idx[6:0]};
    lru_val = ~dir_addr.set_idx[7];
    if (acc_data_in && req.write && tag_consistent(tag_access, new_size)) begin
      if (new_global || ((new_size != eff_size0) && (new_size != eff_size1))) begin
        full_wr = 1'b1;
        full_wr_idx = full_victim;
      end else begin
        set_wr = 1'b1;
        set_wr_idx = {in_half, in_way, in_set};
        lru_wr = 1'b1;
        lru_idx = {in_half, in_set};
        lru_val = ~in_way;
      end
    end
    if (acc_data_acc && req.write && (!new_valid || tag_consistent(tag_access, new_size))) begin
      full_wr = dir_addr.full;
      set_wr = dir_addr.set;
      lru_wr = dir_addr.set;
      // An invalidated way becomes the next victim of its set.
      lru_val = new_valid ? ~dir_addr.set_idx[7] : dir_addr.set_idx[7];
    end
  end

  plru_tree16 full_plru (
    .clk(clk),
    .rst(rst),
    .touch(full_wr),
    .touch_idx(full_wr_idx),
    .victim(full_victim)
  );

  // Entry arrays carry no reset; software invalidates them.
  always_ff @(posedge clk) begin
    if (full_wr) begin
      full_tag[full_wr_idx] <= tag_access;
      full_data[full_wr_idx] <= req.wdata;
    end
    if (set_wr) begin
      set_tag[set_wr_idx] <= tag_access;
      set_data[set_wr_idx] <= req.wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      set_lru <= '0;
    end else if (lru_wr) begin
      set_lru[lru_idx] <= lru_val;
    end
  end

  // Tag access: a trap in the same cycle as a software write wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tag_access <= REG_RESET;
    end else if (trap.valid) begin
      tag_access <= {trap.va, trap.eff_ctx};
    end else if (acc_reg && req.write && (req.va == VA_TAG_ACCESS)) begin
      tag_access <= req.wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tag_access_ext <= REG_RESET;
    end else if (trap.valid && !trap.access_exc) begin
      tag_access_ext <= REG_RESET;
      tag_access_ext[SECOND_SET_TLB_PAGE_SIZE_LO +: 3] <= trap.second_set_tlb_page_size;
      tag_access_ext[FIRST_SET_TLB_PAGE_SIZE_LO +: 3] <= trap.first_set_tlb_page_size;
    end else if (acc_reg && req.write && (req.va == VA_TAG_ACCESS_EXT)) begin
      tag_access_ext <= req.wdata & TAG_EXT_MASK;
    end
  end

  // The buffer base is kept for software only; nothing inside reads it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      translation_buffer_base <= REG_RESET;
    end else if (acc_reg && req.write && (req.va == VA_TRANSLATION_BUFFER_BASE)) begin
      translation_buffer_base <= req.wdata & TRANSLATION_BUFFER_BASE_MASK;
    end
  end

  // Read data selection.
  logic [63:0] entry_tag;
  logic [63:0] entry_data;
  logic [63:0] next_resp_data;

  always_comb begin
    entry_tag = REG_RESET;
    entry_data = REG_RESET;
    if (dir_addr.full) begin
      entry_tag = full_tag[dir_addr.full_idx];
      entry_data = full_data[dir_addr.full_idx];
    end else if (dir_addr.set) begin
      entry_tag = set_tag[dir_addr.set_idx];
      entry_data = set_data[dir_addr.set_idx];
    end
    next_resp_data = REG_RESET;
    if (req.valid && !req.write && !acc_refused) begin
      if (acc_reg) begin
        case (req.va)
          VA_TAG_ACCESS: begin
            next_resp_data = tag_access;
          end
          VA_TAG_ACCESS_EXT: begin
            next_resp_data = tag_access_ext;
          end
          VA_TRANSLATION_BUFFER_BASE: begin
            next_resp_data = translation_buffer_base;
          end
          default: begin
            next_resp_data = REG_RESET;
          end
        endcase
      end else if (acc_data_acc && entry_data[TTE_VALID_POS]) begin
        next_resp_data = entry_data;
      end else if (acc_tag_read && entry_data[TTE_VALID_POS]) begin
        next_resp_data = entry_tag;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_data <= REG_RESET;
    end else begin
      resp_valid <= req.valid;
      resp_data <= next_resp_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      access_exception <= 1'b0;
    end else begin
      access_exception <= acc_refused;
    end
  end

endmodule

// ==== mmu_tlb_chk.sv ====
// Port-level assertions for the TLB maintenance block.
`timescale 1ns/1ps
module mmu_tlb_chk
  import mmu_tlb_pkg::*;
#(
  parameter bit is_data_mmu = 1'b1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire access_req_t req,
  input wire trap_info_t trap,
  input wire logic instr_multi_page_enable,
  input wire logic data_multi_page_enable,
  input wire logic resp_valid,
  input wire logic [63:0] resp_data,
  input wire logic access_exception
);
  logic [7:0] rsp;
  logic [7:0] dacc;
  logic refused;
  logic rreg;
  assign rsp = is_data_mmu ? DMMU_REG_ASI : IMMU_REG_ASI;
  assign dacc = is_data_mmu ? DMMU_DATA_ACC_ASI : IMMU_DATA_ACC_ASI;
  assign rreg = req.valid && !req.write && req.asi == rsp;
  // The three pointer spaces sit just above the register space on both sides.
  assign refused = req.valid && ((req.asi > rsp && req.asi < rsp + 8'h04) || (req.asi == rsp &&
    (req.va == VA_TSB_EXT_PRIM || req.va == VA_TSB_EXT_SEC || req.va == VA_TSB_EXT_NUC)));
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_answer_follows: assert property (req.valid |=> resp_valid) else $error("no answer after access");
  chk_no_stray_answer: assert property (!req.valid |=> !resp_valid) else $error("answer without access");
  chk_refused_flagged: assert property (refused |=> access_exception) else $error("refused access not flagged");
  chk_legal_unflagged: assert property (req.valid && !refused |=> !access_exception) else $error("legal access flagged");
  chk_refused_data_zero: assert property (access_exception |-> resp_valid && resp_data == 64'h0) else $error("refused data");
  chk_store_data_zero: assert property (req.valid && req.write |=> resp_data == 64'h0) else $error("store returned data");
  chk_ext_bits_only: assert property (rreg && req.va == VA_TAG_ACCESS_EXT |=> (resp_data & ~TAG_EXT_MASK) == 64'h0)
    else $error("ext read stray bits");
  chk_base_bits_only: assert property (rreg && req.va == VA_TRANSLATION_BUFFER_BASE |=> (resp_data & ~TRANSLATION_BUFFER_BASE_MASK) == 64'h0)
    else $error("base read stray bits");
  chk_reserved_sel_zero: assert property (req.valid && !req.write && req.asi == dacc && req.va[16] |=> resp_data == 64'h0)
    else $error("reserved select returned data");
endmodule

// ==== tb_mmu_tlb_maintenance_regs.sv ====
// Self-checking bench for the data-side TLB maintenance block.
`timescale 1ns/1ps
module tb_mmu_tlb_maintenance_regs;
  import mmu_tlb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  access_req_t req = '0;
  trap_info_t trap = '0;
  logic instr_multi_page_enable = 1'b0;
  logic data_multi_page_enable = 1'b0;
  logic resp_valid;
  logic [63:0] resp_data;
  logic access_exception;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [63:0] rd;
  logic ex;
  localparam logic [63:0] TAG = 64'h0000_0012_3450_0ABC;
  localparam logic [63:0] TA = 64'h8000_0000_0AB0_2000;
  localparam logic [63:0] TB = 64'h8000_0000_0BC0_4000;
  mmu_tlb_maintenance_regs #(.is_data_mmu(1'b1)) dut (.clk(clk), .rst(rst), .req(req), .trap(trap),
    .instr_multi_page_enable(instr_multi_page_enable), .data_multi_page_enable(data_multi_page_enable),
    .resp_valid(resp_valid), .resp_data(resp_data), .access_exception(access_exception));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    checked++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // The request stays up after a call so that calls run back to back; idle drops it.
  task automatic acc(input logic wr, input logic [7:0] asi, input logic [17:0] va, input logic [63:0] wd);
    req <= '{valid: 1'b1, write: wr, asi: asi, va: va, wdata: wd};
    @(negedge clk);
    rd = resp_data;
    ex = access_exception;
  endtask
  task automatic idle();
    req.valid <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rdchk(input logic [7:0] asi, input logic [17:0] va, input logic [63:0] want);
    acc(1'b0, asi, va, 64'h0);
    check(rd, want);
  endtask
  task automatic put(input logic [17:0] va, input logic [63:0] d);
    acc(1'b1, DMMU_DATA_ACC_ASI, va, d);
  endtask
  task automatic clear_full();
    for (int i = 0; i < 16; i++) put(18'(i * 8), 64'h0);
  endtask
  task automatic count_full(input logic [63:0] d, input int want);
    int n;
    n = 0;
    for (int i = 0; i < 16; i++) begin
      acc(1'b0, DMMU_DATA_ACC_ASI, 18'(i * 8), 64'h0);
      if (rd === d) n++;
    end
    check(64'(n), 64'(want));
  endtask
  task automatic t_regs();
    rdchk(DMMU_REG_ASI, VA_TAG_ACCESS, 64'h0);
    rdchk(DMMU_REG_ASI, VA_TAG_ACCESS_EXT, 64'h0);
    acc(1'b1, DMMU_REG_ASI, VA_TRANSLATION_BUFFER_BASE, 64'hFFFF_FFFF_FFFF_FFFF);
    rdchk(DMMU_REG_ASI, VA_TRANSLATION_BUFFER_BASE, TRANSLATION_BUFFER_BASE_MASK);
  endtask
  task automatic t_refuse();
    logic [7:0] asis [6] = '{DMMU_PTR8K_ASI, DMMU_PTR64K_ASI, DMMU_PTRDIR_ASI, DMMU_REG_ASI, DMMU_REG_ASI, DMMU_REG_ASI};
    logic [17:0] vas [6] = '{VA_TAG_ACCESS, VA_TAG_ACCESS, VA_TAG_ACCESS,
      VA_TSB_EXT_PRIM, VA_TSB_EXT_SEC, VA_TSB_EXT_NUC};
    acc(1'b1, DMMU_REG_ASI, VA_TAG_ACCESS, TAG);
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, asis[i], vas[i], 64'h0);
      check(64'(ex), 64'h1);
      acc(1'b0, asis[i], vas[i], 64'h0);
      check(64'(ex), 64'h1);
    end
    rdchk(DMMU_REG_ASI, VA_TAG_ACCESS, TAG);
    idle();
  endtask
  task automatic t_trap();
    trap <= '{valid: 1'b1, access_exc: 1'b0, va: 51'h12_3456_789A, eff_ctx: 13'h1ABC,
      first_set_tlb_page_size: 3'h5, second_set_tlb_page_size: 3'h2};
    @(negedge clk);
    trap <= '{valid: 1'b1, access_exc: 1'b1, va: 51'h1, eff_ctx: 13'h00AB,
      first_set_tlb_page_size: 3'h1, second_set_tlb_page_size: 3'h1};
    @(negedge clk);
    trap.valid <= 1'b0;
    rdchk(DMMU_REG_ASI, VA_TAG_ACCESS, 64'h0000_0000_0000_20AB);
    trap.valid <= 1'b0;
    rdchk(DMMU_REG_ASI, VA_TAG_ACCESS_EXT, 64'h0000_0000_0015_0000);
    idle();
  endtask
  task automatic t_direct();
    acc(1'b1, DMMU_REG_ASI, VA_TAG_ACCESS, TAG);
    put(18'h0_3FA8, TA);
    rdchk(DMMU_DATA_ACC_ASI, 18'h0_0028, TA);
    rdchk(DMMU_TAG_READ_ASI, 18'h0_1C28, TAG);
    put(18'h2_3EA8, TB);
    rdchk(DMMU_DATA_ACC_ASI, 18'h2_32A8, TB);
    put(18'h1_0028, TB);
    rdchk(DMMU_DATA_ACC_ASI, 18'h1_0028, 64'h0);
    put(18'h0_0030, TA);
    put(18'h0_0030, 64'hE000_0000_0EF0_0000);
    rdchk(DMMU_DATA_ACC_ASI, 18'h0_0030, TA);
    put(18'h0_0030, 64'h6001_0000_0000_2000);
    rdchk(DMMU_DATA_ACC_ASI, 18'h0_0030, 64'h0);
    idle();
  endtask
  task automatic t_datain();
    clear_full();
    acc(1'b1, DMMU_DATA_IN_ASI, 18'h0, TA | 64'h1);
    count_full(TA | 64'h1, 1);
    clear_full();
    acc(1'b1, DMMU_DATA_IN_ASI, 18'h0, 64'hA000_0000_0CD0_0000);
    count_full(64'hA000_0000_0CD0_0000, 1);
    clear_full();
    put(18'h2_0000, 64'h0);
    put(18'h2_1000, 64'h0);
    acc(1'b1, DMMU_DATA_IN_ASI, 18'h0, TA);
    acc(1'b1, DMMU_DATA_IN_ASI, 18'h0, TB);
    count_full(TA, 0);
    rdchk(DMMU_DATA_ACC_ASI, 18'h2_1000, TA);
    rdchk(DMMU_DATA_ACC_ASI, 18'h2_0000, TB);
    idle();
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_refuse();
    t_trap();
    t_direct();
    t_datain();
    conclude();
  end
endmodule
bind mmu_tlb_maintenance_regs mmu_tlb_chk #(.is_data_mmu(is_data_mmu)) chk (.clk(clk), .rst(rst), .req(req),
  .trap(trap), .instr_multi_page_enable(instr_multi_page_enable), .data_multi_page_enable(data_multi_page_enable),
  .resp_valid(resp_valid), .resp_data(resp_data), .access_exception(access_exception));
